//--- inc/dc_coupled_subsample_cmd_map.vh
// register map, field positions and codes of the sub-sampling controller
`ifndef DC_COUPLED_SUBSAMPLE_CMD_MAP_VH
`define DC_COUPLED_SUBSAMPLE_CMD_MAP_VH
`define DC_COUPLED_SUBSAMPLE_CMD_A_CMD      8'h00
`define DC_COUPLED_SUBSAMPLE_CMD_A_PEAK     8'h04
`define DC_COUPLED_SUBSAMPLE_CMD_A_CFG      8'h08
`define DC_COUPLED_SUBSAMPLE_CMD_A_LEVEL    8'h0C
`define DC_COUPLED_SUBSAMPLE_CMD_A_INTV     8'h10
`define DC_COUPLED_SUBSAMPLE_CMD_A_COUNT    8'h14
`define DC_COUPLED_SUBSAMPLE_CMD_A_STAT     8'h18
`define DC_COUPLED_SUBSAMPLE_CMD_A_N1       8'h1C
`define DC_COUPLED_SUBSAMPLE_CMD_A_N2       8'h20
`define DC_COUPLED_SUBSAMPLE_CMD_A_N        8'h24
`define DC_COUPLED_SUBSAMPLE_CMD_A_MCNT     8'h28
`define DC_COUPLED_SUBSAMPLE_CMD_OP_LSB     0
`define DC_COUPLED_SUBSAMPLE_CMD_OP_MSB     2
`define DC_COUPLED_SUBSAMPLE_CMD_OP_ACSUB   3'h1
`define DC_COUPLED_SUBSAMPLE_CMD_OP_DCSUB   3'h2
`define DC_COUPLED_SUBSAMPLE_CMD_OP_FUNC    3'h3
`define DC_COUPLED_SUBSAMPLE_CMD_OP_RDGCNT  3'h4
`define DC_COUPLED_SUBSAMPLE_CMD_OP_FIFO    3'h5
`define DC_COUPLED_SUBSAMPLE_CMD_OP_ARM     3'h6
`define DC_COUPLED_SUBSAMPLE_CMD_OP_ERRCLR  3'h7
`define DC_COUPLED_SUBSAMPLE_CMD_CMD_PEAKGV 8
`define DC_COUPLED_SUBSAMPLE_CMD_CFG_MEMEN  0
`define DC_COUPLED_SUBSAMPLE_CMD_CFG_OENC_L 1
`define DC_COUPLED_SUBSAMPLE_CMD_CFG_OENC_H 2
`define DC_COUPLED_SUBSAMPLE_CMD_CFG_MENC_L 3
`define DC_COUPLED_SUBSAMPLE_CMD_CFG_MENC_H 4
`define DC_COUPLED_SUBSAMPLE_CMD_CFG_SYNCX  5
`define DC_COUPLED_SUBSAMPLE_CMD_CFG_HOLD   6
`define DC_COUPLED_SUBSAMPLE_CMD_CFG_SACM   7
`define DC_COUPLED_SUBSAMPLE_CMD_CFG_BW_L   8
`define DC_COUPLED_SUBSAMPLE_CMD_CFG_BW_H   9
`define DC_COUPLED_SUBSAMPLE_CMD_CFG_AZ     10
`define DC_COUPLED_SUBSAMPLE_CMD_CFG_AR     11
`define DC_COUPLED_SUBSAMPLE_CMD_ENC_SHORT  2'h0
`define DC_COUPLED_SUBSAMPLE_CMD_ENC_DINT   2'h1
`define DC_COUPLED_SUBSAMPLE_CMD_ENC_DOUBLE 2'h2
`define DC_COUPLED_SUBSAMPLE_CMD_PK_R0      32'h0000_000C
`define DC_COUPLED_SUBSAMPLE_CMD_PK_R1      32'h0000_0078
`define DC_COUPLED_SUBSAMPLE_CMD_PK_R2      32'h0000_04B0
`define DC_COUPLED_SUBSAMPLE_CMD_PK_R3      32'h0000_2EE0
`define DC_COUPLED_SUBSAMPLE_CMD_PK_R4      32'h0001_D4C0
`define DC_COUPLED_SUBSAMPLE_CMD_PK_R5      32'h000F_4240
`define DC_COUPLED_SUBSAMPLE_CMD_RNG_10V    3'h3
`define DC_COUPLED_SUBSAMPLE_CMD_LVL_MAX    32'h0000_01F4
`define DC_COUPLED_SUBSAMPLE_CMD_MIN_INT_NS 32'h0000_000A
`define DC_COUPLED_SUBSAMPLE_CMD_CLK_NS     32'h0000_0032
`endif

//--- src/dc_coupled_subsample_cmd_ctrl.v
// sub-sampled digitizer command interpreter with wishbone register access
// How it works
// - peak value picks one of six fixed ranges
// - no autorange while sub-sampling
// - resolution argument accepted and discarded
// - subsample command suspends autozero and autorange
// - level up to 500%, samples clip 120%
// - memory off forces output encoding short integer
// - function change restores previous output encoding
// - memory on leaves output encoding alone
// - arm checks fifo, empty, short integer memory
// - fifo mode select empties sample memory
// - trigger and per-sample events are ignored
// - memory writes reordered into time order
// - sweep sets spacing, reading count rejected
// - use enough input periods for spacing
// - spacing below ten nanoseconds is rejected
// - query gives n1, n2, then n
// - bursts start on external or level sync
// - hold stops random fallback; timeout from bandwidth
// - ac variant strips dc, dc keeps it
// - each sample held by track-and-hold strobe
`timescale 1ns/1ps
`default_nettype none
`include "dc_coupled_subsample_cmd_map.vh"
module dc_coupled_subsample_cmd_ctrl #(
  parameter DW          = 16,
  parameter MAW         = 16,
  parameter MIN_REAL_NS = 20000,
  parameter CLIP_MAX    = 29491,
  parameter TMO_BASE    = 40000
) (
  input  wire          clk_i,
  input  wire          rst_i,
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  input  wire          wb_we_i,
  input  wire [7:0]    wb_adr_i,
  input  wire [3:0]    wb_sel_i,
  input  wire [31:0]   wb_dat_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  input  wire          ext_sync_i,
  input  wire          level_cross_i,
  input  wire [DW-1:0] adc_data_i,
  output reg           hold_strobe_o,
  output reg           ac_coupled_o,
  output wire          autozero_o,
  output wire          autorange_o,
  output reg  [2:0]    range_o,
  output reg           random_fallback_o,
  output reg           mem_we_o,
  output reg  [MAW-1:0] mem_addr_o,
  output reg  [DW-1:0] mem_data_o,
  output reg           out_valid_o,
  output reg  [DW-1:0] out_data_o
);

  localparam S_IDLE  = 4'b0001;
  localparam S_CALC  = 4'b0010;
  localparam S_WSYNC = 4'b0100;
  localparam S_BURST = 4'b1000;

  reg  [3:0]  state_r;
  reg         active_r;
  reg         forced_r;
  reg  [1:0]  saved_enc_r;
  reg  [31:0] cfg_r;
  reg  [31:0] peak_r;
  reg  [31:0] level_r;
  reg  [31:0] intv_r;
  reg  [31:0] count_r;
  reg  [31:0] mcnt_r;
  reg         conflict_r;
  reg         reject_r;
  reg         done_r;
  reg  [31:0] nb_r;
  reg  [31:0] acc_r;
  reg  [31:0] tot_r;
  reg  [31:0] nper_r;
  reg  [31:0] n1_r;
  reg  [31:0] n2_r;
  reg         phase_r;
  reg  [31:0] bidx_r;
  reg  [31:0] sidx_r;
  reg  [31:0] tns_r;
  reg  [31:0] next_r;
  reg  [31:0] offs_r;
  reg  [31:0] addr_r;
  reg  [31:0] tmo_r;

  wire        wb_req = wb_cyc_i & wb_stb_i;
  wire        wr_go  = wb_req & wb_ack_o & wb_we_i;
  wire [2:0]  op     = wb_dat_i[`DC_COUPLED_SUBSAMPLE_CMD_OP_MSB:`DC_COUPLED_SUBSAMPLE_CMD_OP_LSB];
  wire        is_cmd = wr_go & (wb_adr_i == `DC_COUPLED_SUBSAMPLE_CMD_A_CMD);
  // sync is taken as a level; the far side gives one-cycle pulses
  wire        sync_ev = cfg_r[`DC_COUPLED_SUBSAMPLE_CMD_CFG_SYNCX] ? ext_sync_i : level_cross_i;
  wire [1:0]  bw     = cfg_r[`DC_COUPLED_SUBSAMPLE_CMD_CFG_BW_H:`DC_COUPLED_SUBSAMPLE_CMD_CFG_BW_L];
  // fallback timeout doubles with each bandwidth step
  wire [31:0] tmo_lim = TMO_BASE << bw;
  wire [31:0] cnt_this = (bidx_r < n1_r) ? nper_r : nper_r - 32'h0000_0001;
  wire        mem_en = cfg_r[`DC_COUPLED_SUBSAMPLE_CMD_CFG_MEMEN];
  wire        fifo_md;
  reg         fifo_r;
  reg  [2:0]  rng_nxt;
  reg  [DW-1:0] clip_nxt;

  // status word; busy means any state but idle
  wire [31:0] stat_w = {21'h0_0000,
                        fifo_r,
                        done_r,
                        ~state_r[0],
                        reject_r,
                        conflict_r,
                        forced_r,
                        range_o,
                        ac_coupled_o,
                        active_r};

  assign fifo_md = fifo_r;

  // autozero and autorange forced off while sub-sampling
  assign autozero_o  = cfg_r[`DC_COUPLED_SUBSAMPLE_CMD_CFG_AZ] & ~active_r;
  assign autorange_o = cfg_r[`DC_COUPLED_SUBSAMPLE_CMD_CFG_AR] & ~active_r;

  always @* begin
    if (peak_r <= `DC_COUPLED_SUBSAMPLE_CMD_PK_R0)
      rng_nxt = 3'h0;
    else if (peak_r <= `DC_COUPLED_SUBSAMPLE_CMD_PK_R1)
      rng_nxt = 3'h1;
    else if (peak_r <= `DC_COUPLED_SUBSAMPLE_CMD_PK_R2)
      rng_nxt = 3'h2;
    else if (peak_r <= `DC_COUPLED_SUBSAMPLE_CMD_PK_R3)
      rng_nxt = 3'h3;
    else if (peak_r <= `DC_COUPLED_SUBSAMPLE_CMD_PK_R4)
      rng_nxt = 3'h4;
    else
      rng_nxt = 3'h5;
  end

  // short integer code only spans 120% of range, so larger samples saturate
  always @* begin
    if ($signed(adc_data_i) > $signed(CLIP_MAX[DW-1:0]))
      clip_nxt = CLIP_MAX[DW-1:0];
    else if ($signed(adc_data_i) < -$signed(CLIP_MAX[DW-1:0]))
      clip_nxt = -CLIP_MAX[DW-1:0];
    else
      clip_nxt = adc_data_i;
  end

  // wishbone: ack one cycle after the request, dropped the cycle after
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      case (wb_adr_i)
        `DC_COUPLED_SUBSAMPLE_CMD_A_PEAK:  wb_dat_o <= peak_r;
        `DC_COUPLED_SUBSAMPLE_CMD_A_CFG:   wb_dat_o <= cfg_r;
        `DC_COUPLED_SUBSAMPLE_CMD_A_LEVEL: wb_dat_o <= level_r;
        `DC_COUPLED_SUBSAMPLE_CMD_A_INTV:  wb_dat_o <= intv_r;
        `DC_COUPLED_SUBSAMPLE_CMD_A_COUNT: wb_dat_o <= count_r;
        `DC_COUPLED_SUBSAMPLE_CMD_A_STAT:  wb_dat_o <= stat_w;
        `DC_COUPLED_SUBSAMPLE_CMD_A_N1:    wb_dat_o <= n1_r;
        `DC_COUPLED_SUBSAMPLE_CMD_A_N2:    wb_dat_o <= n2_r;
        `DC_COUPLED_SUBSAMPLE_CMD_A_N:     wb_dat_o <= nper_r;
        `DC_COUPLED_SUBSAMPLE_CMD_A_MCNT:  wb_dat_o <= mcnt_r;
        default:       wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // configuration and command execution
  always @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r        <= 32'h0000_0000;
      peak_r       <= `DC_COUPLED_SUBSAMPLE_CMD_PK_R3;
      level_r      <= 32'h0000_0000;
      intv_r       <= `DC_COUPLED_SUBSAMPLE_CMD_MIN_INT_NS;
      count_r      <= 32'h0000_0001;
      active_r     <= 1'b0;
      forced_r     <= 1'b0;
      saved_enc_r  <= `DC_COUPLED_SUBSAMPLE_CMD_ENC_SHORT;
      ac_coupled_o <= 1'b0;
      range_o      <= `DC_COUPLED_SUBSAMPLE_CMD_RNG_10V;
      fifo_r       <= 1'b0;
      reject_r     <= 1'b0;
    end else begin
      if (wr_go && wb_adr_i == `DC_COUPLED_SUBSAMPLE_CMD_A_CFG)
        cfg_r <= {20'h0_0000, wb_dat_i[11:0]};
      if (wr_go && wb_adr_i == `DC_COUPLED_SUBSAMPLE_CMD_A_PEAK)
        peak_r <= wb_dat_i;
      if (wr_go && wb_adr_i == `DC_COUPLED_SUBSAMPLE_CMD_A_LEVEL) begin
        if (wb_dat_i <= `DC_COUPLED_SUBSAMPLE_CMD_LVL_MAX)
          level_r <= wb_dat_i;
        else
          reject_r <= 1'b1;
      end
      if (wr_go && wb_adr_i == `DC_COUPLED_SUBSAMPLE_CMD_A_INTV) begin
        if (wb_dat_i >= `DC_COUPLED_SUBSAMPLE_CMD_MIN_INT_NS)
          intv_r <= wb_dat_i;
        else
          reject_r <= 1'b1;
      end
      if (wr_go && wb_adr_i == `DC_COUPLED_SUBSAMPLE_CMD_A_COUNT && wb_dat_i != 32'h0000_0000)
        count_r <= wb_dat_i;
      // a command in the same cycle as a cfg write wins the encoding bits
      if (is_cmd) begin
        case (op)
          `DC_COUPLED_SUBSAMPLE_CMD_OP_ACSUB, `DC_COUPLED_SUBSAMPLE_CMD_OP_DCSUB: begin
            // bits 31:16 carry the resolution argument, never read
            active_r     <= 1'b1;
            ac_coupled_o <= (op == `DC_COUPLED_SUBSAMPLE_CMD_OP_ACSUB);
            if (wb_dat_i[`DC_COUPLED_SUBSAMPLE_CMD_CMD_PEAKGV])
              range_o <= rng_nxt;
            else
              range_o <= `DC_COUPLED_SUBSAMPLE_CMD_RNG_10V;
            if (!mem_en && !forced_r) begin
              forced_r    <= 1'b1;
              saved_enc_r <= cfg_r[`DC_COUPLED_SUBSAMPLE_CMD_CFG_OENC_H:`DC_COUPLED_SUBSAMPLE_CMD_CFG_OENC_L];
              cfg_r[`DC_COUPLED_SUBSAMPLE_CMD_CFG_OENC_H:`DC_COUPLED_SUBSAMPLE_CMD_CFG_OENC_L] <= `DC_COUPLED_SUBSAMPLE_CMD_ENC_SHORT;
            end
          end
          `DC_COUPLED_SUBSAMPLE_CMD_OP_FUNC: begin
            active_r <= 1'b0;
            forced_r <= 1'b0;
            if (forced_r)
              cfg_r[`DC_COUPLED_SUBSAMPLE_CMD_CFG_OENC_H:`DC_COUPLED_SUBSAMPLE_CMD_CFG_OENC_L] <= saved_enc_r;
          end
          `DC_COUPLED_SUBSAMPLE_CMD_OP_RDGCNT: begin
            if (active_r)
              reject_r <= 1'b1;
          end
          `DC_COUPLED_SUBSAMPLE_CMD_OP_FIFO: fifo_r <= 1'b1;
          `DC_COUPLED_SUBSAMPLE_CMD_OP_ERRCLR: reject_r <= 1'b0;
          default: ;
        endcase
      end
    end
  end

  // acquisition sequencer; trigger and per-sample events have no input here
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r           <= S_IDLE;
      conflict_r        <= 1'b0;
      done_r            <= 1'b0;
      mcnt_r            <= 32'h0000_0000;
      nb_r              <= 32'h0000_0001;
      acc_r             <= 32'h0000_0000;
      tot_r             <= 32'h0000_0000;
      nper_r            <= 32'h0000_0000;
      n1_r              <= 32'h0000_0000;
      n2_r              <= 32'h0000_0000;
      phase_r           <= 1'b0;
      bidx_r            <= 32'h0000_0000;
      sidx_r            <= 32'h0000_0000;
      tns_r             <= 32'h0000_0000;
      next_r            <= 32'h0000_0000;
      offs_r            <= 32'h0000_0000;
      addr_r            <= 32'h0000_0000;
      tmo_r             <= 32'h0000_0000;
      random_fallback_o <= 1'b0;
      hold_strobe_o     <= 1'b0;
      mem_we_o          <= 1'b0;
      mem_addr_o        <= {MAW{1'b0}};
      mem_data_o        <= {DW{1'b0}};
      out_valid_o       <= 1'b0;
      out_data_o        <= {DW{1'b0}};
    end else begin
      hold_strobe_o <= 1'b0;
      mem_we_o      <= 1'b0;
      out_valid_o   <= 1'b0;
      if (is_cmd && op == `DC_COUPLED_SUBSAMPLE_CMD_OP_FIFO)
        mcnt_r <= 32'h0000_0000;
      if (is_cmd && op == `DC_COUPLED_SUBSAMPLE_CMD_OP_ERRCLR)
        conflict_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          // arm outside sub-sampling is ignored rather than flagged
          if (is_cmd && op == `DC_COUPLED_SUBSAMPLE_CMD_OP_ARM && active_r) begin
            if (mem_en && (!fifo_md || mcnt_r != 32'h0000_0000 ||
                cfg_r[`DC_COUPLED_SUBSAMPLE_CMD_CFG_MENC_H:`DC_COUPLED_SUBSAMPLE_CMD_CFG_MENC_L] != `DC_COUPLED_SUBSAMPLE_CMD_ENC_SHORT)) begin
              conflict_r <= 1'b1;
            end else begin
              done_r  <= 1'b0;
              nb_r    <= 32'h0000_0001;
              acc_r   <= intv_r;
              tot_r   <= 32'h0000_0000;
              nper_r  <= 32'h0000_0000;
              phase_r <= 1'b0;
              state_r <= S_CALC;
            end
          end
        end
        S_CALC: begin
          if (!phase_r) begin
            // more bursts until the real spacing nb*interval is reachable
            if (acc_r < MIN_REAL_NS) begin
              acc_r <= acc_r + intv_r;
              nb_r  <= nb_r + 32'h0000_0001;
            end else begin
              phase_r <= 1'b1;
            end
          end else if (tot_r < count_r) begin
            // n grows until n samples in each of nb bursts cover the count
            tot_r  <= tot_r + nb_r;
            nper_r <= nper_r + 32'h0000_0001;
          end else begin
            n1_r    <= count_r - (tot_r - nb_r);
            n2_r    <= tot_r - count_r;
            bidx_r  <= 32'h0000_0000;
            offs_r  <= 32'h0000_0000;
            tmo_r   <= 32'h0000_0000;
            state_r <= S_WSYNC;
          end
        end
        // a missing sync never ends the wait; hold only keeps the fallback flag low
        S_WSYNC: begin
          tmo_r <= tmo_r + 32'h0000_0001;
          if (sync_ev) begin
            tmo_r   <= 32'h0000_0000;
            tns_r   <= 32'h0000_0000;
            next_r  <= offs_r;
            sidx_r  <= 32'h0000_0000;
            addr_r  <= bidx_r;
            state_r <= S_BURST;
          end else if (cfg_r[`DC_COUPLED_SUBSAMPLE_CMD_CFG_SACM] && !cfg_r[`DC_COUPLED_SUBSAMPLE_CMD_CFG_HOLD] && tmo_r >= tmo_lim) begin
            random_fallback_o <= 1'b1;
          end
        end
        // burst i starts i intervals after its sync, so memory order is time order
        S_BURST: begin
          tns_r <= tns_r + `DC_COUPLED_SUBSAMPLE_CMD_CLK_NS;
          if (tns_r >= next_r) begin
            hold_strobe_o <= 1'b1;
            next_r <= next_r + acc_r;
            addr_r <= addr_r + nb_r;
            sidx_r <= sidx_r + 32'h0000_0001;
            if (mem_en) begin
              mem_we_o   <= 1'b1;
              mem_addr_o <= addr_r[MAW-1:0];
              mem_data_o <= clip_nxt;
              mcnt_r     <= mcnt_r + 32'h0000_0001;
            end else begin
              out_valid_o <= 1'b1;
              out_data_o  <= clip_nxt;
            end
            if (sidx_r + 32'h0000_0001 >= cnt_this) begin
              bidx_r <= bidx_r + 32'h0000_0001;
              offs_r <= offs_r + intv_r;
              if (bidx_r + 32'h0000_0001 >= nb_r) begin
                done_r            <= 1'b1;
                random_fallback_o <= 1'b0;
                state_r           <= S_IDLE;
              end else begin
                state_r <= S_WSYNC;
              end
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- tb/dc_coupled_subsample_cmd_assertions.sv
// port checks for the sub-sampling controller
`timescale 1ns/1ps
`default_nettype none
module dc_coupled_subsample_cmd_chk #(
  parameter DW       = 16,
  parameter CLIP_MAX = 29491
) (
  input wire          clk_i,
  input wire          rst_i,
  input wire          wb_cyc_i,
  input wire          wb_stb_i,
  input wire          wb_ack_o,
  input wire          hold_strobe_o,
  input wire          autozero_o,
  input wire          autorange_o,
  input wire [2:0]    range_o,
  input wire          mem_we_o,
  input wire [DW-1:0] mem_data_o,
  input wire          out_valid_o,
  input wire [DW-1:0] out_data_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_quiet: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_range_legal: assert property (range_o <= 3'h5)
    else $error("range code beyond top range");
  a_range_fixed: assert property (hold_strobe_o |-> $stable(range_o))
    else $error("range moved while sampling");
  a_auto_off: assert property (hold_strobe_o |-> !autozero_o && !autorange_o)
    else $error("autozero or autorange live while sampling");
  a_clip_out: assert property (out_valid_o |-> $signed(out_data_o) <= CLIP_MAX)
    else $error("output sample above clip");
  a_clip_mem: assert property (mem_we_o |-> $signed(mem_data_o) <= CLIP_MAX)
    else $error("stored sample above clip");
  a_strobe_gap: assert property (hold_strobe_o |=> !hold_strobe_o [*3])
    else $error("samples closer than the burst spacing");
  a_one_path: assert property (!(mem_we_o && out_valid_o))
    else $error("sample sent to memory and output at once");
endmodule
bind dc_coupled_subsample_cmd_ctrl dc_coupled_subsample_cmd_chk #(.DW(DW), .CLIP_MAX(CLIP_MAX)) chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .hold_strobe_o, .autozero_o, .autorange_o, .range_o, .mem_we_o, .mem_data_o, .out_valid_o, .out_data_o);
`default_nettype wire

//--- tb/dc_coupled_subsample_cmd_sync_src.sv
// periodic sync and sample source standing at the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module dc_coupled_subsample_cmd_sync_src #(
  parameter int PER = 40
) (
  input  wire logic        clk_i,
  input  wire logic        en_i,
  input  wire logic        ext_sel_i,
  output var  logic        ext_sync_o,
  output var  logic        level_cross_o,
  output var  logic [15:0] adc_o
);
  int cnt = 0;
  initial begin
    ext_sync_o = 1'b0;
    level_cross_o = 1'b0;
    adc_o = 16'h000F;
  end
  // one sync per input period, only on the chosen line; idle low otherwise
  always @(posedge clk_i) begin
    cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    ext_sync_o <= en_i && ext_sel_i && cnt == 0;
    level_cross_o <= en_i && !ext_sel_i && cnt == 0;
    // every other sample is over full scale, so clipping is exercised
    adc_o <= adc_o ^ 16'h7FF0;
  end
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the sub-sampling controller
`timescale 1ns/1ps
`default_nettype none
`include "dc_coupled_subsample_cmd_map.vh"
module tb;
  localparam int MINR = 200;
  localparam int NB   = (MINR + 49) / 50;
  localparam int NS   = (22 + NB - 1) / NB;
  localparam int N1   = 22 - NB * (NS - 1);
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic        cyc     = 1'b0;
  logic        we      = 1'b0;
  logic        src_en  = 1'b0;
  logic        src_ext = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [31:0] wdat    = 32'h0000_0000;
  logic [31:0] rdat;
  logic [63:0] hit     = 64'h0;
  wire  [31:0] dat_o;
  wire  [15:0] adc, mem_addr, odat, mdat;
  wire         ack, xsync, lsync, fallback, mem_we, out_valid, azero, arange, ac_cpl;
  int          error_cnt   = 0;
  int          comparisons = 0;
  int          outs        = 0;
  logic [31:0] pk [6] = '{`DC_COUPLED_SUBSAMPLE_CMD_PK_R0, `DC_COUPLED_SUBSAMPLE_CMD_PK_R1, `DC_COUPLED_SUBSAMPLE_CMD_PK_R2, `DC_COUPLED_SUBSAMPLE_CMD_PK_R3, `DC_COUPLED_SUBSAMPLE_CMD_PK_R4, `DC_COUPLED_SUBSAMPLE_CMD_PK_R5};
  logic [7:0]  ra [5] = '{`DC_COUPLED_SUBSAMPLE_CMD_A_INTV, `DC_COUPLED_SUBSAMPLE_CMD_A_INTV, `DC_COUPLED_SUBSAMPLE_CMD_A_LEVEL, `DC_COUPLED_SUBSAMPLE_CMD_A_LEVEL, `DC_COUPLED_SUBSAMPLE_CMD_A_CMD};
  logic [31:0] rv [5] = '{32'h0000_0009, 32'h0000_0032, 32'h0000_01F5, 32'h0000_01F4, 32'h0000_0004};
  dc_coupled_subsample_cmd_ctrl #(.MIN_REAL_NS(MINR), .TMO_BASE(50)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .ext_sync_i(xsync), .level_cross_i(lsync), .adc_data_i(adc), .hold_strobe_o(),
    .ac_coupled_o(ac_cpl), .autozero_o(azero), .autorange_o(arange), .range_o(), .random_fallback_o(fallback),
    .mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_data_o(mdat), .out_valid_o(out_valid), .out_data_o(odat));
  dc_coupled_subsample_cmd_sync_src src_u (.clk_i(clk_i), .en_i(src_en), .ext_sel_i(src_ext), .ext_sync_o(xsync),
    .level_cross_o(lsync), .adc_o(adc));
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (mem_we === 1'b1) hit[mem_addr[5:0]] <= 1'b1;
    if (out_valid === 1'b1) outs <= outs + 1;
    if (mem_we === 1'b1) chk(mdat == 16'h000F || mdat == 16'h7333, 1'b1);
    if (out_valid === 1'b1) chk(odat == 16'h000F || odat == 16'h7333, 1'b1);
  end
  task automatic conclude();
    if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] sv, input logic [31:0] ev);
    comparisons++;
    if (sv !== ev) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, sv, ev);
    end
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    if (ack !== 1'b1) begin
      error_cnt++;
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin
      rd(`DC_COUPLED_SUBSAMPLE_CMD_A_STAT);
      n++;
    end while (rdat[8] !== 1'b0 && n < 500);
    if (rdat[8] !== 1'b0) begin
      error_cnt++;
      conclude();
    end
    chk(rdat[9:8], 2'b10);
  endtask
  task automatic fbwait(input logic want);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (fallback !== 1'b1 && n < 200);
    if (want && fallback !== 1'b1) begin
      error_cnt++;
      conclude();
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`DC_COUPLED_SUBSAMPLE_CMD_A_STAT);
    chk(rdat[4:2], `DC_COUPLED_SUBSAMPLE_CMD_RNG_10V);
    wr(`DC_COUPLED_SUBSAMPLE_CMD_A_CFG, 32'h0000_0C0C);
    rd(8'h3C);
    chk(rdat, 32'h0000_0000);
    chk({azero, arange}, 2'b11);
    // each range boundary, and the value just above every boundary but the top one
    for (int i = 0; i < 11; i++) begin
      wr(`DC_COUPLED_SUBSAMPLE_CMD_A_PEAK, pk[i / 2] + i % 2);
      wr(`DC_COUPLED_SUBSAMPLE_CMD_A_CMD, 32'hABCD_0102);
      rd(`DC_COUPLED_SUBSAMPLE_CMD_A_STAT);
      chk(rdat[4:2], (i + 1) / 2);
    end
    chk(ac_cpl, 1'b0);
    rd(`DC_COUPLED_SUBSAMPLE_CMD_A_CFG);
    chk(rdat[4:1], {`DC_COUPLED_SUBSAMPLE_CMD_ENC_DINT, `DC_COUPLED_SUBSAMPLE_CMD_ENC_SHORT});
    chk(azero | arange, 1'b0);
    wr(`DC_COUPLED_SUBSAMPLE_CMD_A_CMD, 32'h0000_0001);
    rd(`DC_COUPLED_SUBSAMPLE_CMD_A_STAT);
    chk({rdat[5], rdat[4:2], ac_cpl}, {1'b1, `DC_COUPLED_SUBSAMPLE_CMD_RNG_10V, 1'b1});
    wr(`DC_COUPLED_SUBSAMPLE_CMD_A_CMD, 32'h0000_0003);
    rd(`DC_COUPLED_SUBSAMPLE_CMD_A_CFG);
    chk({rdat[2:1], azero}, {`DC_COUPLED_SUBSAMPLE_CMD_ENC_DOUBLE, 1'b1});
    wr(`DC_COUPLED_SUBSAMPLE_CMD_A_CFG, 32'h0000_0C0D);
    wr(`DC_COUPLED_SUBSAMPLE_CMD_A_CMD, 32'h0000_0002);
    wr(`DC_COUPLED_SUBSAMPLE_CMD_A_CMD, 32'h0000_0006);
    rd(`DC_COUPLED_SUBSAMPLE_CMD_A_CFG);
    chk(rdat[2:1], `DC_COUPLED_SUBSAMPLE_CMD_ENC_DOUBLE);
    rd(`DC_COUPLED_SUBSAMPLE_CMD_A_STAT);
    chk({rdat[6], rdat[8], hit[31:0]}, 34'h2_0000_0000);
    wr(`DC_COUPLED_SUBSAMPLE_CMD_A_CMD, 32'h0000_0005);
    wr(`DC_COUPLED_SUBSAMPLE_CMD_A_CFG, 32'h0000_0C25);
    rd(`DC_COUPLED_SUBSAMPLE_CMD_A_STAT);
    chk(rdat[10], 1'b1);
    rd(`DC_COUPLED_SUBSAMPLE_CMD_A_MCNT);
    chk(rdat, 32'h0000_0000);
    for (int i = 0; i < 5; i++) begin
      wr(`DC_COUPLED_SUBSAMPLE_CMD_A_CMD, 32'h0000_0007);
      wr(ra[i], rv[i]);
      rd(`DC_COUPLED_SUBSAMPLE_CMD_A_STAT);
      chk(rdat[7], i % 2 == 0);
    end
    wr(`DC_COUPLED_SUBSAMPLE_CMD_A_CMD, 32'h0000_0007);
    wr(`DC_COUPLED_SUBSAMPLE_CMD_A_COUNT, 32'h0000_0016);
    src_ext <= 1'b1;
    src_en <= 1'b1;
    wr(`DC_COUPLED_SUBSAMPLE_CMD_A_CMD, 32'h0000_0006);
    idle();
    chk(hit[31:0], 32'h003F_FFFF);
    rd(`DC_COUPLED_SUBSAMPLE_CMD_A_MCNT);
    chk(rdat, 32'h0000_0016);
    wr(`DC_COUPLED_SUBSAMPLE_CMD_A_CMD, 32'h0000_0005);
    rd(`DC_COUPLED_SUBSAMPLE_CMD_A_MCNT);
    chk(rdat, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      rd(8'(`DC_COUPLED_SUBSAMPLE_CMD_A_N1 + 4 * i));
      chk(rdat, i == 0 ? N1 : i == 1 ? NB - N1 : NS);
    end
    src_ext <= 1'b0;
    wr(`DC_COUPLED_SUBSAMPLE_CMD_A_CFG, 32'h0000_0C04);
    wr(`DC_COUPLED_SUBSAMPLE_CMD_A_CMD, 32'h0000_0002);
    rd(`DC_COUPLED_SUBSAMPLE_CMD_A_CFG);
    chk(rdat[2:1], `DC_COUPLED_SUBSAMPLE_CMD_ENC_SHORT);
    wr(`DC_COUPLED_SUBSAMPLE_CMD_A_CMD, 32'h0000_0006);
    idle();
    chk(outs, 32'h0000_0016);
    src_en <= 1'b0;
    wr(`DC_COUPLED_SUBSAMPLE_CMD_A_CFG, 32'h0000_0080);
    wr(`DC_COUPLED_SUBSAMPLE_CMD_A_CMD, 32'h0000_0006);
    fbwait(1'b1);
    chk(fallback, 1'b1);
    // reset mid-run, then the same wait with hold set
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`DC_COUPLED_SUBSAMPLE_CMD_A_STAT);
    chk({fallback, rdat[10:0]}, 12'h00C);
    wr(`DC_COUPLED_SUBSAMPLE_CMD_A_INTV, 32'h0000_0032);
    wr(`DC_COUPLED_SUBSAMPLE_CMD_A_COUNT, 32'h0000_0016);
    wr(`DC_COUPLED_SUBSAMPLE_CMD_A_CFG, 32'h0000_00C0);
    wr(`DC_COUPLED_SUBSAMPLE_CMD_A_CMD, 32'h0000_0002);
    wr(`DC_COUPLED_SUBSAMPLE_CMD_A_CMD, 32'h0000_0006);
    fbwait(1'b0);
    chk(fallback, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
